// ==== inc/rdi_defs.vh ====
`ifndef RDI_DEFS_VH
`define RDI_DEFS_VH

// ---------------------------------------------------------------
// register byte offsets within the frame
// ---------------------------------------------------------------
`define RDI_OFS_TYPE_LO     16'h0008
`define RDI_OFS_TYPE_HI     16'h000C
`define RDI_OFS_ERR_STATUS  16'h0010
`define RDI_OFS_SETPEND_LO  16'h0040
`define RDI_OFS_SETPEND_HI  16'h0044
`define RDI_OFS_CFGBASE_LO  16'h0070
`define RDI_OFS_CFGBASE_HI  16'h0074
`define RDI_OFS_PENDBASE_LO 16'h0078
`define RDI_OFS_PENDBASE_HI 16'h007C
`define RDI_OFS_CLRPEND_LO  16'h0048
`define RDI_OFS_CLRPEND_HI  16'h004C
`define RDI_OFS_INVONE_LO   16'h00A0
`define RDI_OFS_INVONE_HI   16'h00A4
`define RDI_OFS_INVALL_LO   16'h00B0
`define RDI_OFS_INVALL_HI   16'h00B4
`define RDI_OFS_SYNC        16'h00C0
`define RDI_OFS_SYNC_HI     16'h00C4

// ---------------------------------------------------------------
// error-status field positions
// ---------------------------------------------------------------
`define RDI_ERR_READ_RSVD   0
`define RDI_ERR_WRITE_RSVD  1
`define RDI_ERR_READ_WO     2
`define RDI_ERR_WRITE_RO    3

// ---------------------------------------------------------------
// type register field positions (within the 64-bit word)
// ---------------------------------------------------------------
`define RDI_TYP_PHYS_SUPP   0
`define RDI_TYP_VIRT_SUPP   1
`define RDI_TYP_DIRECT      3
`define RDI_TYP_LAST        4
`define RDI_TYP_DEACT       5
`define RDI_TYP_PROC_LSB    8
`define RDI_TYP_SHARE_LSB   24
`define RDI_TYP_AFFINITY_LEVEL0_LSB    32

// ---------------------------------------------------------------
// timing and reset values
// ---------------------------------------------------------------
`define RDI_OP_CYCLES       8'h10
`define RDI_ZERO32          32'h0000_0000
`define RDI_ZERO64          64'h0000_0000_0000_0000

`endif

// ==== core/rdi_regs.v ====
`timescale 1ns/1ps
`default_nettype none
`include "rdi_defs.vh"

module rdi_regs #(
   parameter         ID_MAX_BITS   = 16,
   parameter         NUM_INTR      = 64,
   parameter         INTR_BASE     = 8192,
   parameter         HAS_ERR_STAT  = 1,
   parameter         TWO_SECURITY  = 1,
   parameter         SYNC_STALL    = 0,
   parameter [7:0]   AFFINITY_LEVEL3          = 8'h00,
   parameter [7:0]   AFFINITY_LEVEL2          = 8'h00,
   parameter [7:0]   AFFINITY_LEVEL1          = 8'h00,
   parameter [7:0]   AFFINITY_LEVEL0          = 8'h00,
   parameter [1:0]   SHARE_LEVEL   = 2'h0,
   parameter [15:0]  PROC_NUM      = 16'h0000,
   parameter         DEACT_SUPP    = 0,
   parameter         IS_LAST       = 1,
   parameter         DIRECT_SUPP   = 1,
   parameter         VIRT_SUPP     = 0,
   parameter         PHYS_SUPP     = 1
) (
   // clock and reset
   input  wire                CLK,
   input  wire                RST_N,
   // register access, one-cycle strobes
   input  wire                REG_WR,
   input  wire                REG_RD,
   input  wire [15:0]         REG_ADDR,
   input  wire [31:0]         REG_WDATA,
   input  wire                REG_NONSECURE,
   output reg  [31:0]         REG_RDATA,
   output reg                 REG_RVALID,
   // redistributor control
   input  wire                MESSAGE_INTERRUPT_ENABLE,
   input  wire [4:0]          IDENTIFIER_BITS,
   // pending state and its external clear
   input  wire [NUM_INTR-1:0] PEND_CLEAR,
   output reg  [NUM_INTR-1:0] PENDING,
   output reg                 SET_PULSE,
   // table base outputs
   output reg  [63:0]         CFG_TABLE_BASE,
   output reg  [63:0]         PEND_TABLE_BASE
);

   // ---------------------------------------------------------------
   // fixed type word
   // ---------------------------------------------------------------
   // every field comes from a parameter, so the word is pure wiring;
   // a processor number that is not unique across the system breaks
   // legacy target selection, and nothing here can detect that
   // reserved bits 31:26, 7:6 and 2 are tied low by the literals
   // bit 3 must stay set while the set-pending and sync offsets exist
   wire [63:0] type_word;
   assign type_word = {AFFINITY_LEVEL3, AFFINITY_LEVEL2, AFFINITY_LEVEL1, AFFINITY_LEVEL0,
                       6'h00, SHARE_LEVEL,
                       PROC_NUM,
                       2'h0,
                       (DEACT_SUPP != 0),
                       (IS_LAST != 0),
                       (DIRECT_SUPP != 0),
                       1'b0,
                       (VIRT_SUPP != 0),
                       (PHYS_SUPP != 0)};

   // ---------------------------------------------------------------
   // address classification
   // ---------------------------------------------------------------
   // both halves of each 64-bit register are listed, so a lone high
   // word access classifies like the low word; any offset not named
   // here is reserved and feeds the error flags below
   reg is_ro;
   reg is_wo;
   reg is_rw;
   always @* begin
      is_ro = 1'b0;
      is_wo = 1'b0;
      is_rw = 1'b0;
      if (REG_ADDR == `RDI_OFS_TYPE_LO || REG_ADDR == `RDI_OFS_TYPE_HI ||
          REG_ADDR == `RDI_OFS_SYNC || REG_ADDR == `RDI_OFS_SYNC_HI) begin
         is_ro = 1'b1;
      end else if (REG_ADDR == `RDI_OFS_SETPEND_LO ||
                   REG_ADDR == `RDI_OFS_SETPEND_HI ||
                   REG_ADDR == `RDI_OFS_CLRPEND_LO ||
                   REG_ADDR == `RDI_OFS_CLRPEND_HI ||
                   REG_ADDR == `RDI_OFS_INVONE_LO ||
                   REG_ADDR == `RDI_OFS_INVONE_HI ||
                   REG_ADDR == `RDI_OFS_INVALL_LO ||
                   REG_ADDR == `RDI_OFS_INVALL_HI) begin
         is_wo = 1'b1;
      end else if (REG_ADDR == `RDI_OFS_ERR_STATUS ||
                   REG_ADDR == `RDI_OFS_CFGBASE_LO ||
                   REG_ADDR == `RDI_OFS_CFGBASE_HI ||
                   REG_ADDR == `RDI_OFS_PENDBASE_LO ||
                   REG_ADDR == `RDI_OFS_PENDBASE_HI) begin
         is_rw = 1'b1;
      end
   end

   // reserved means no class matched; the whole 16-bit offset counts,
   // so aliases above the frame are reserved too
   wire is_rsvd;
   assign is_rsvd = ~(is_ro | is_wo | is_rw);

   // ---------------------------------------------------------------
   // set-pending decode
   // ---------------------------------------------------------------
   // low-word write carries the id; a high-word write also reaches set_id,
   // but set_wr decodes only the low offset, so a high-word write injects nothing
   wire [63:0] set_data;
   assign set_data = {`RDI_ZERO32, REG_WDATA};
   wire [31:0] set_id;
   assign set_id = set_data[31:0];

   // identifier width from the smaller of setting and implementation
   // a setting below 13 bits masks every id under the first message
   // interrupt, so every write then falls out of range and is ignored
   wire [5:0]  eff_bits;
   assign eff_bits = ({1'b0, IDENTIFIER_BITS} + 6'h01 > ID_MAX_BITS) ?
                     ID_MAX_BITS[5:0] : ({1'b0, IDENTIFIER_BITS} + 6'h01);
   wire [31:0] id_mask;
   assign id_mask = (eff_bits >= 6'h20) ? 32'hFFFF_FFFF :
                    ((32'h0000_0001 << eff_bits) - 32'h0000_0001);
   wire [31:0] id_eff;
   assign id_eff = set_id & id_mask;
   // offset into the provided range; it wraps for ids below the base,
   // which the lower-bound test catches
   wire [31:0] id_off;
   assign id_off = id_eff - INTR_BASE[31:0];
   wire id_ok;
   assign id_ok = (id_eff >= INTR_BASE[31:0]) &&
                  (id_off < NUM_INTR[31:0]);

   // enable, range and word checks gate the strobe before any state
   wire set_wr;
   assign set_wr = REG_WR && REG_ADDR == `RDI_OFS_SETPEND_LO &&
                   MESSAGE_INTERRUPT_ENABLE && id_ok;

   // ---------------------------------------------------------------
   // pending bits, one per provided interrupt
   // ---------------------------------------------------------------
   // a set in the same cycle as a downstream clear wins, so an id that
   // is injected again while being consumed is never lost
   // bit i holds the id at the base plus i; ids past the range never
   // reach a bit, so no decode wraps
   genvar gi;
   generate
      for (gi = 0; gi < NUM_INTR; gi = gi + 1) begin : g_pend
         always @(posedge CLK or negedge RST_N) begin
            if (!RST_N) begin
               PENDING[gi] <= 1'b0;
            end else if (set_wr && id_off == gi) begin
               PENDING[gi] <= 1'b1;
            end else if (PEND_CLEAR[gi]) begin
               PENDING[gi] <= 1'b0;
            end
         end
      end
   endgenerate

   // pulse only on a real transition; re-setting is silent
   // the pulse looks at the pending bit before this edge's update
   // downstream uses the pulse as the new-event strobe of the id
   always @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         SET_PULSE <= 1'b0;
      end else begin
         SET_PULSE <= set_wr && !PENDING[id_off[15:0] % NUM_INTR];
      end
   end

   // ---------------------------------------------------------------
   // table base registers and operation timer
   // ---------------------------------------------------------------
   // writes to the clear, invalidate and table base offsets all start
   // the same timer; reads of them never do
   reg  [7:0] op_count;
   wire       op_start;
   assign op_start = REG_WR && (
                     REG_ADDR == `RDI_OFS_CLRPEND_LO ||
                     REG_ADDR == `RDI_OFS_CLRPEND_HI ||
                     REG_ADDR == `RDI_OFS_INVONE_LO ||
                     REG_ADDR == `RDI_OFS_INVONE_HI ||
                     REG_ADDR == `RDI_OFS_INVALL_LO ||
                     REG_ADDR == `RDI_OFS_INVALL_HI ||
                     REG_ADDR == `RDI_OFS_CFGBASE_LO ||
                     REG_ADDR == `RDI_OFS_CFGBASE_HI ||
                     REG_ADDR == `RDI_OFS_PENDBASE_LO ||
                     REG_ADDR == `RDI_OFS_PENDBASE_HI);

   // the group-equality of the base is left to software
   // both tables are plain storage; no field is checked or masked
   always @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         CFG_TABLE_BASE  <= `RDI_ZERO64;
         PEND_TABLE_BASE <= `RDI_ZERO64;
      end else if (REG_WR) begin
         if (REG_ADDR == `RDI_OFS_CFGBASE_LO) begin
            CFG_TABLE_BASE[31:0] <= REG_WDATA;
         end else if (REG_ADDR == `RDI_OFS_CFGBASE_HI) begin
            CFG_TABLE_BASE[63:32] <= REG_WDATA;
         end else if (REG_ADDR == `RDI_OFS_PENDBASE_LO) begin
            PEND_TABLE_BASE[31:0] <= REG_WDATA;
         end else if (REG_ADDR == `RDI_OFS_PENDBASE_HI) begin
            PEND_TABLE_BASE[63:32] <= REG_WDATA;
         end
      end
   end

   // fixed latency model of the table walk behind each operation
   // a new operation restarts the count instead of queueing, so busy
   // always covers the most recent write in full
   always @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         op_count <= 8'h00;
      end else if (op_start) begin
         op_count <= `RDI_OP_CYCLES;
      end else if (op_count != 8'h00) begin
         op_count <= op_count - 8'h01;
      end
   end

   // derived, not stored: busy drops in the cycle the count ends
   wire busy;
   assign busy = (op_count != 8'h00);

   // ---------------------------------------------------------------
   // banked error status
   // ---------------------------------------------------------------
   reg  [3:0] err_s;
   reg  [3:0] err_ns;
   // without a second security state every access uses one bank
   wire       bank_ns;
   assign bank_ns = (TWO_SECURITY != 0) && REG_NONSECURE;

   // an access raises at most one flag: the classes are exclusive
   wire [3:0] err_evt;
   assign err_evt = {REG_WR & is_ro,
                     REG_RD & is_wo,
                     REG_WR & is_rsvd,
                     REG_RD & is_rsvd};

   // write-one-to-clear; zeros in the data leave flags untouched
   wire [3:0] err_clr;
   assign err_clr = (REG_WR && REG_ADDR == `RDI_OFS_ERR_STATUS) ?
                    REG_WDATA[3:0] : 4'h0;

   // a new event beats a clear in the same cycle
   // only the bank of the current access moves; the other bank keeps
   // its flags, so one security state cannot hide the other's errors
   always @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         err_s  <= 4'h0;
         err_ns <= 4'h0;
      end else if (HAS_ERR_STAT != 0) begin
         if (bank_ns) begin
            err_ns <= (err_ns & ~err_clr) | err_evt;
         end else begin
            err_s  <= (err_s & ~err_clr) | err_evt;
         end
      end
   end

   // ---------------------------------------------------------------
   // read data path, answer one cycle after the strobe, or once idle for a stalled sync read
   // ---------------------------------------------------------------
   // write-only and reserved offsets read zero; the error flags are
   // the only trace of such a read
   // the high half of sync holds no field and reads zero
   reg [31:0] next_rdata;
   always @* begin
      next_rdata = `RDI_ZERO32;
      if (REG_ADDR == `RDI_OFS_TYPE_LO) begin
         next_rdata = type_word[31:0];
      end else if (REG_ADDR == `RDI_OFS_TYPE_HI) begin
         next_rdata = type_word[63:32];
      end else if (REG_ADDR == `RDI_OFS_ERR_STATUS) begin
         if (HAS_ERR_STAT != 0) begin
            next_rdata = {28'h0000000, bank_ns ? err_ns : err_s};
         end
      end else if (REG_ADDR == `RDI_OFS_SYNC) begin
         next_rdata = {31'h00000000, busy};
      end else if (REG_ADDR == `RDI_OFS_CFGBASE_LO) begin
         next_rdata = CFG_TABLE_BASE[31:0];
      end else if (REG_ADDR == `RDI_OFS_CFGBASE_HI) begin
         next_rdata = CFG_TABLE_BASE[63:32];
      end else if (REG_ADDR == `RDI_OFS_PENDBASE_LO) begin
         next_rdata = PEND_TABLE_BASE[31:0];
      end else if (REG_ADDR == `RDI_OFS_PENDBASE_HI) begin
         next_rdata = PEND_TABLE_BASE[63:32];
      end
   end

   // a stalled sync read waits for idle, so busy then reads 0
   // while a stalled read is open a further read strobe is dropped;
   // the bus must not issue one until the answer has come
   // with stalling off the sync read answers at once, busy included
   reg rd_wait;
   wire sync_rd;
   assign sync_rd = REG_RD && REG_ADDR == `RDI_OFS_SYNC;
   always @(posedge CLK or negedge RST_N) begin
      if (!RST_N) begin
         REG_RDATA  <= `RDI_ZERO32;
         REG_RVALID <= 1'b0;
         rd_wait    <= 1'b0;
      end else if (SYNC_STALL != 0 && (rd_wait || (sync_rd && busy))) begin
         rd_wait    <= busy;
         REG_RVALID <= !busy;
         REG_RDATA  <= `RDI_ZERO32;
      end else begin
         REG_RVALID <= REG_RD;
         REG_RDATA  <= REG_RD ? next_rdata : `RDI_ZERO32;
      end
   end

endmodule

`default_nettype wire

// ==== testbench/rdi_checker.sv ====
`timescale 1ns/1ps
`default_nettype none
module rdi_checker #(
   parameter NUM_INTR = 64
) (
   // clock and reset
   input wire logic                CLK,
   input wire logic                RST_N,
   // register access
   input wire logic                REG_WR,
   input wire logic                REG_RD,
   input wire logic [15:0]         REG_ADDR,
   input wire logic [31:0]         REG_WDATA,
   input wire logic                REG_NONSECURE,
   input wire logic [31:0]         REG_RDATA,
   input wire logic                REG_RVALID,
   // control and pending state
   input wire logic                MESSAGE_INTERRUPT_ENABLE,
   input wire logic [4:0]          IDENTIFIER_BITS,
   input wire logic [NUM_INTR-1:0] PEND_CLEAR,
   input wire logic [NUM_INTR-1:0] PENDING,
   input wire logic                SET_PULSE,
   input wire logic [63:0]         CFG_TABLE_BASE,
   input wire logic [63:0]         PEND_TABLE_BASE
);
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RST_N);
   // ---------------------------------------------------------------
   // decode helpers
   // ---------------------------------------------------------------
   // identifier hits only count when the mask keeps all sixteen bits
   wire [31:0] set_ofs = REG_WDATA - 32'h0000_2000;
   wire        set_wr  = REG_WR && (REG_ADDR == 16'h0040);
   wire        low16   = (REG_WDATA[31:16] == 16'h0000) &&
                         (IDENTIFIER_BITS >= 5'h0F);
   wire        hit     = low16 && (REG_WDATA >= 32'h0000_2000) &&
                         (set_ofs < NUM_INTR);
   wire        op_wr   = REG_WR && ((REG_ADDR == 16'h0070) ||
                         (REG_ADDR == 16'h0078) || (REG_ADDR == 16'h0048) ||
                         (REG_ADDR == 16'h00A0) || (REG_ADDR == 16'h00B0));
   wire        sync_rd = REG_RD && (REG_ADDR == 16'h00C0);
   wire        err_rd  = REG_RD && (REG_ADDR == 16'h0010);
   // ---------------------------------------------------------------
   // assertions
   // ---------------------------------------------------------------
   a_set_marks_pending: assert property (
      set_wr && MESSAGE_INTERRUPT_ENABLE && hit && !PENDING[set_ofs]
      |=> SET_PULSE && PENDING[$past(set_ofs)])
      else $error("set-pending write did not mark the interrupt");
   a_pulse_needs_write: assert property (
      SET_PULSE |-> $past(set_wr) && $past(MESSAGE_INTERRUPT_ENABLE))
      else $error("set pulse without an enabled set-pending write");
   a_high_word_quiet: assert property (
      REG_WR && (REG_ADDR == 16'h0044) |=> !SET_PULSE)
      else $error("high word write made an interrupt pending");
   a_pending_no_repeat: assert property (
      set_wr && hit && PENDING[set_ofs] |=> !SET_PULSE)
      else $error("set of an already pending interrupt had effect");
   a_range_miss_quiet: assert property (
      set_wr && low16 && !hit |=> !SET_PULSE)
      else $error("set of an unprovided interrupt had effect");
   a_disabled_quiet: assert property (
      set_wr && !MESSAGE_INTERRUPT_ENABLE |=> !SET_PULSE)
      else $error("set-pending write acted while disabled");
   a_err_write_ro: assert property (
      REG_WR && (REG_ADDR == 16'h0008) ##1 err_rd && $stable(REG_NONSECURE)
      |=> REG_RVALID && REG_RDATA[3])
      else $error("write to read-only place not flagged");
   a_err_read_wo: assert property (
      REG_RD && (REG_ADDR == 16'h0040) ##1 !REG_WR ##1
      err_rd && $stable(REG_NONSECURE) |=> REG_RVALID && REG_RDATA[2])
      else $error("read of write-only place not flagged");
   a_flag_w1c: assert property (
      REG_WR && (REG_ADDR == 16'h0010) && REG_WDATA[0] ##1
      err_rd && $stable(REG_NONSECURE) |=> REG_RVALID && !REG_RDATA[0])
      else $error("write of one did not clear the read-reserved flag");
   a_busy_after_op: assert property (
      op_wr ##1 sync_rd |=> REG_RVALID && (REG_RDATA == 32'h0000_0001))
      else $error("sync not busy right after an operation write");
   // main scenarios reached
   c_set: cover property (set_wr && hit ##1 SET_PULSE);
   c_busy: cover property (op_wr ##1 sync_rd);
   c_err: cover property (err_rd ##1 REG_RDATA != 32'h0000_0000);
endmodule

bind rdi_regs rdi_checker #(.NUM_INTR(NUM_INTR)) u_rdi_checker (
   .CLK(CLK), .RST_N(RST_N), .REG_WR(REG_WR), .REG_RD(REG_RD),
   .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
   .REG_NONSECURE(REG_NONSECURE), .REG_RDATA(REG_RDATA),
   .REG_RVALID(REG_RVALID),
   .MESSAGE_INTERRUPT_ENABLE(MESSAGE_INTERRUPT_ENABLE),
   .IDENTIFIER_BITS(IDENTIFIER_BITS), .PEND_CLEAR(PEND_CLEAR),
   .PENDING(PENDING), .SET_PULSE(SET_PULSE),
   .CFG_TABLE_BASE(CFG_TABLE_BASE), .PEND_TABLE_BASE(PEND_TABLE_BASE));
`default_nettype wire

// ==== testbench/rdi_testbench.sv ====
`timescale 1ns/1ps
`default_nettype none
module testbench;
   // ---------------------------------------------------------------
   // signals and expectations
   // ---------------------------------------------------------------
   localparam [1:0]  SHR    = 2'h2;
   localparam [15:0] PNUM   = 16'h5A3C;
   localparam [31:0] TYP_LO = {6'h00, SHR, PNUM, 2'h0, 6'b101011};
   localparam [31:0] TYP_HI = {8'hA1, 8'hB2, 8'hC3, 8'hD4};
   logic        CLK, RST_N, REG_WR, REG_RD, REG_NONSECURE;
   logic        MESSAGE_INTERRUPT_ENABLE;
   logic [15:0] REG_ADDR;
   logic [31:0] REG_WDATA;
   logic [4:0]  IDENTIFIER_BITS;
   logic [63:0] PEND_CLEAR, exp_pend;
   wire  [31:0] REG_RDATA;
   wire         REG_RVALID, SET_PULSE;
   wire  [63:0] PENDING, CFG_TABLE_BASE, PEND_TABLE_BASE;
   int          err_count, compares, i;
   logic [15:0] op_addr [5] = '{16'h0070, 16'h0078, 16'h0048, 16'h00A0,
                                16'h00B0};

   // device with distinct type fields so misplaced bits show
   rdi_regs #(.AFFINITY_LEVEL3(TYP_HI[31:24]), .AFFINITY_LEVEL2(TYP_HI[23:16]),
      .AFFINITY_LEVEL1(TYP_HI[15:8]), .AFFINITY_LEVEL0(TYP_HI[7:0]),
      .SHARE_LEVEL(SHR), .PROC_NUM(PNUM), .DEACT_SUPP(1), .IS_LAST(0),
      .VIRT_SUPP(1)) u_rdi_regs (
      .CLK(CLK), .RST_N(RST_N), .REG_WR(REG_WR), .REG_RD(REG_RD),
      .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
      .REG_NONSECURE(REG_NONSECURE), .REG_RDATA(REG_RDATA),
      .REG_RVALID(REG_RVALID),
      .MESSAGE_INTERRUPT_ENABLE(MESSAGE_INTERRUPT_ENABLE),
      .IDENTIFIER_BITS(IDENTIFIER_BITS), .PEND_CLEAR(PEND_CLEAR),
      .PENDING(PENDING), .SET_PULSE(SET_PULSE),
      .CFG_TABLE_BASE(CFG_TABLE_BASE), .PEND_TABLE_BASE(PEND_TABLE_BASE));

   // ---------------------------------------------------------------
   // access tasks, all entered at a falling edge
   // ---------------------------------------------------------------
   task automatic cmp(input string what, input logic [63:0] exp, got);
      compares++;
      if (got !== exp) begin
         err_count++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask
   // strobe stays up if another write follows at once
   task automatic wr(input logic [15:0] a, input logic [31:0] d);
      REG_RD    = 1'b0;
      REG_WR    = 1'b1;
      REG_ADDR  = a;
      REG_WDATA = d;
      @(negedge CLK);
   endtask
   // answer is looked at in its single valid cycle; mask 0 skips it
   task automatic rd(input logic [15:0] a, input logic [31:0] exp, mask);
      REG_WR   = 1'b0;
      REG_RD   = 1'b1;
      REG_ADDR = a;
      @(negedge CLK);
      if (mask != 32'h0) begin
         cmp("read valid", 64'h1, {63'h0, REG_RVALID});
         cmp($sformatf("read %h", a), {32'h0, exp},
             {32'h0, REG_RDATA & mask});
      end
      REG_RD = 1'b0;
      @(negedge CLK);
   endtask
   task automatic setp(input logic [15:0] a, input logic [31:0] d,
                       input logic en, input logic [4:0] idb,
                       input logic pulse, input int idx);
      MESSAGE_INTERRUPT_ENABLE = en;
      IDENTIFIER_BITS          = idb;
      wr(a, d);
      REG_WR = 1'b0;
      cmp("set pulse", {63'h0, pulse}, {63'h0, SET_PULSE});
      if (pulse) exp_pend[idx] = 1'b1;
      cmp("pending", exp_pend, PENDING);
      @(negedge CLK);
   endtask
   task automatic end_of_test;
      $display("compares %0d, err_count %0d", compares, err_count);
      if (err_count == 0 && compares > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask

   // ---------------------------------------------------------------
   // clock, watchdog and test sequence
   // ---------------------------------------------------------------
   initial begin
      CLK = 1'b0;
      forever #12.5 CLK = ~CLK;
   end
   // whole sequence needs well under a thousand cycles
   initial begin
      repeat (4000) @(posedge CLK);
      err_count++;
      end_of_test();
   end
   initial begin
      {RST_N, REG_WR, REG_RD, REG_NONSECURE} = 4'h0;
      {REG_ADDR, REG_WDATA, PEND_CLEAR, exp_pend} = '0;
      MESSAGE_INTERRUPT_ENABLE = 1'b1;
      IDENTIFIER_BITS          = 5'h0F;
      repeat (20) @(negedge CLK);
      RST_N = 1'b1;
      cmp("reset", 64'h0, PENDING | CFG_TABLE_BASE | PEND_TABLE_BASE);
      cmp("reset bus", 64'h0, {30'h0, REG_RVALID, SET_PULSE, REG_RDATA});
      rd(16'h0010, 32'h0, 32'h0000_000F);
      setp(16'h0040, 32'h0000_2005, 1'b1, 5'h0F, 1'b1, 5);
      setp(16'h0040, 32'h0000_2005, 1'b1, 5'h0F, 1'b0, 0);
      setp(16'h0040, 32'h0000_203F, 1'b1, 5'h0F, 1'b1, 63);
      setp(16'h0040, 32'h0000_2040, 1'b1, 5'h0F, 1'b0, 0);
      setp(16'h0040, 32'h0000_1FFF, 1'b1, 5'h0F, 1'b0, 0);
      setp(16'h0044, 32'h0000_2007, 1'b1, 5'h0F, 1'b0, 0);
      setp(16'h0040, 32'h0001_2000, 1'b1, 5'h0F, 1'b1, 0);
      setp(16'h0040, 32'h0000_2009, 1'b0, 5'h0F, 1'b0, 0);
      setp(16'h0040, 32'h0000_200A, 1'b1, 5'h0C, 1'b0, 0);
      PEND_CLEAR = 64'h0000_0000_0000_0020;
      @(negedge CLK);
      PEND_CLEAR  = 64'h0;
      exp_pend[5] = 1'b0;
      setp(16'h0040, 32'h0000_2005, 1'b1, 5'h0F, 1'b1, 5);
      // error flags, secure bank first, then the other bank
      wr(16'h0008, 32'hFFFF_FFFF);
      rd(16'h0010, 32'h8, 32'h0000_000F);
      wr(16'h0010, 32'h8);
      rd(16'h0010, 32'h0, 32'h0000_000F);
      REG_NONSECURE = 1'b1;
      wr(16'h0300, 32'h1);
      rd(16'h0010, 32'h2, 32'h0000_000F);
      REG_NONSECURE = 1'b0;
      rd(16'h0010, 32'h0, 32'h0000_000F);
      rd(16'h0040, 32'h0, 32'h0);
      rd(16'h0010, 32'h4, 32'h0000_000F);
      rd(16'h0200, 32'h0, 32'h0);
      rd(16'h0010, 32'h5, 32'hFFFF_FFFF);
      wr(16'h0010, 32'h0);
      rd(16'h0010, 32'h5, 32'h0000_000F);
      wr(16'h0010, 32'h1);
      rd(16'h0010, 32'h4, 32'h0000_000F);
      rd(16'h0008, TYP_LO, 32'hFFFF_FFFF);
      rd(16'h000C, TYP_HI, 32'hFFFF_FFFF);
      // each operation write keeps sync busy for a while
      for (i = 0; i < 5; i++) begin
         wr(op_addr[i], 32'h1234_5000);
         rd(16'h00C0, 32'h1, 32'hFFFF_FFFF);
         repeat (20) @(negedge CLK);
         rd(16'h00C0, 32'h0, 32'hFFFF_FFFF);
      end
      cmp("config base", 64'h1234_5000, CFG_TABLE_BASE);
      cmp("pending base", 64'h1234_5000, PEND_TABLE_BASE);
      rd(16'h0070, 32'h1234_5000, 32'hFFFF_FFFF);
      rd(16'h007C, 32'h0, 32'hFFFF_FFFF);
      end_of_test();
   end
endmodule
`default_nettype wire
